// ---- core/cp_dbg_map.svh ----
// Register map and timing constants of the protection debug/status bank.
// Assumes a 100 MHz clock; included by bare name.
`ifndef CP_DBG_MAP_SVH
`define CP_DBG_MAP_SVH
// Printed offsets are not all word multiples: these are register indices
`define IDX_DEBUG_MIRROR   8'hc0
`define IDX_DEBUG_LOCAL    8'hc1
`define IDX_STATUS         8'hc4
`define IDX_IRQ_MASK       8'hc5
`define IDX_IRQ_STATUS     8'hc6
// Mirror fields
`define BIT_TO_DIS         6
`define BIT_CHK_EN         3
`define BIT_FAST_VERIFY    2
`define BIT_SPEEDUP        1
`define BIT_FAST_I2C       0
`define MIRROR_MASK        8'h4f
// Local fields
`define BIT_NO_DECRYPT     1
`define BIT_REENABLE       0
`define LOCAL_MASK         8'h03
`define LOCAL_RST          8'h00
// Status / interrupt fields
`define BIT_CHK_ERR        1
`define BIT_AUTH_DONE      0
`define STS_RST            8'h00
// Interrupt event bits: 0 authenticated, 1 checksum error, 2 auth lost
`define IRQ_W              3
// Timing
`define CLK_MHZ            100
`define BUS_IDLE_MS        1000
`define SPEEDUP_SHIFT      4
`define FRAMES_FAST_P      8'd2
`define FRAMES_FAST_R      8'd16
`define FRAMES_SLOW_P      8'd16
`define FRAMES_SLOW_R      8'd128
`endif

// ---- core/cp_dbg_pkg.sv ----
// Types shared by the protection debug/status bank.
// Assumes cp_dbg_map.svh is on the include path.
package cp_dbg_pkg;
    typedef enum logic [2:0] {
        AHB_IDLE = 3'b001,
        AHB_WR   = 3'b010,
        AHB_RD   = 3'b100
    } ahb_state_t;
    typedef enum logic [2:0] {
        AU_IDLE = 3'b001,
        AU_RUN  = 3'b010,
        AU_DONE = 3'b100
    } auth_state_t;
endpackage : cp_dbg_pkg

// ---- core/line_sum_if.sv ----
// Channel checksum lane bundle between bank top and checksum lanes.
// Assumes one clock owned by the instantiating module.
`timescale 1ns/1ns
`default_nettype none
interface line_sum_if;
    logic       clear;
    logic       pix_vld;
    logic [7:0] pix;
    logic [7:0] sum;
    modport top  (output clear, output pix_vld, output pix, input sum);
    modport lane (input clear, input pix_vld, input pix, output sum);
endinterface : line_sum_if
`default_nettype wire

// ---- core/line_sum_lane.sv ----
// One colour channel ones-complement running sum.
// Assumes clear and pix_vld are on clk_i and never high together.
`timescale 1ns/1ns
`default_nettype none
module line_sum_lane
    import cp_dbg_pkg::*;
(
    input  wire logic clk_i,    // Clock
    input  wire logic rst_n_i,  // Async reset, active low
    line_sum_if.lane  ls        // Lane bundle
);
    typedef struct packed {
        logic [7:0] sum;
    } lane_state_t;
    lane_state_t st_r;
    lane_state_t st_nxt;
    logic [8:0]  add;

    always_comb begin
        st_nxt = st_r;
        add    = {1'b0, st_r.sum} + {1'b0, ls.pix};
        if (ls.clear) begin
            st_nxt.sum = 8'h00;
        end else if (ls.pix_vld) begin
            // End-around carry
            st_nxt.sum = add[7:0] + {7'h00, add[8]};
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ls.sum = ~st_r.sum;
endmodule : line_sum_lane
`default_nettype wire

// ---- core/cp_dbg_bank.sv ----
// Protection-channel debug, control and status register bank with line checksum check.
// Assumes an AHB-Lite master on clk_i; link-side inputs synchronous except mirror bits.
// Functional notes
// - Protection bus controller frees the bus after over 1 s idle when timeout enabled.
// - Timeout disable set: never assume bus free from inactivity.
// - Checksum enabled: per-channel 8-bit ones-complement sum follows each active line.
// - Fast verify set: frame check every 2 frames, integrity every 16.
// - Fast verify clear: frame check every 16 frames, integrity every 128.
// - Timer speed-up makes authentication timers run faster.
// - Bus fast timing set selects fast mode, clear selects standard mode.
// - Mirror debug bits are read-only copies of transmitter settings.
// - Bypass-decrypt set outputs encrypted pixels, everything else normal.
// - Policy 1 skips re-enabling downstream; 0 re-enables at each auth start.
// - Checksum mismatch sets checksum error while checksum is enabled.
// - Any write to status clears checksum error.
// - Authenticated bit sets on successful authentication.
// - Authenticated bit clears on loss or restart of authentication.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "cp_dbg_map.svh"
module cp_dbg_bank
    import cp_dbg_pkg::*;
#(
    parameter int unsigned BUS_IDLE_CYC = `BUS_IDLE_MS * 1000 * `CLK_MHZ
) (
    input  wire logic        clk_i,           // 100 MHz clock
    input  wire logic        rst_n_i,         // Async reset, active low
    input  wire logic        hsel_i,          // AHB slave select
    input  wire logic [31:0] haddr_i,         // AHB address
    input  wire logic [1:0]  htrans_i,        // AHB transfer type
    input  wire logic        hwrite_i,        // AHB write
    input  wire logic [2:0]  hsize_i,         // AHB size
    input  wire logic [31:0] hwdata_i,        // AHB write data
    input  wire logic        hready_i,        // AHB bus ready
    output logic      [31:0] hrdata_o,        // AHB read data
    output logic             hreadyout_o,     // AHB slave ready
    output logic             hresp_o,         // AHB response (OKAY)
    output logic             irq_o,           // Interrupt, level
    input  wire logic [7:0]  tx_debug_i,      // Transmitter debug setting bits
    input  wire logic        bus_activity_i,  // Protection bus signalling seen
    output logic             bus_free_o,      // Protection bus assumed free
    output logic             bus_fast_timing_o, // Fast-mode bus timing select
    input  wire logic        frame_start_i,   // Frame start pulse
    output logic             frame_check_due_o,   // Recompute frame check value
    output logic             link_integrity_due_o, // Recompute link integrity value
    output logic             timer_tick_o,    // Authentication timer tick
    input  wire logic        auth_start_i,    // Authentication start pulse
    input  wire logic        auth_ok_i,       // Authentication success pulse
    input  wire logic        auth_lost_i,     // Authentication lost pulse
    input  wire logic        ds_enabled_i,    // Downstream already protected
    output logic             ds_enable_o,     // Enable downstream protection pulse
    input  wire logic        pix_vld_i,       // Active pixel valid
    input  wire logic        line_end_i,      // End of active line pulse
    input  wire logic        chk_vld_i,       // Received checksum valid
    input  wire logic [23:0] chk_i,           // Received checksums
    input  wire logic [23:0] pix_dec_i,       // Decrypted pixel
    input  wire logic [23:0] pix_enc_i,       // Encrypted pixel
    output logic      [23:0] rgb_o            // Colour output
);
    typedef struct packed {
        ahb_state_t  ahb;
        logic [7:0]  idx;
        logic [7:0]  local_reg;
        logic        chk_err;
        logic        auth_done;
        logic [`IRQ_W-1:0] irq_sts;
        logic [`IRQ_W-1:0] irq_mask;
        logic [31:0] rdata;
        logic [31:0] idle_cnt;
        logic        bus_free;
        logic [7:0]  frame_cnt;
        logic        fc_due;
        logic        li_due;
        logic [7:0]  tmr_div;
        logic        tmr_tick;
        auth_state_t au;
        logic        ds_en;
        logic        chk_pend;
        logic [23:0] rgb;
    } bank_state_t;

    bank_state_t st_r;
    bank_state_t st_nxt;
    logic [7:0]  mir_s1_r;
    logic [7:0]  mir_s2_r;
    logic [23:0] sums;
    logic        lane_clear;
    logic        sum_ok;
    logic        addr_ph;
    logic [7:0]  addr_idx;
    logic [7:0]  p_per;
    logic [7:0]  r_per;
    logic [7:0]  tmr_lim;
    logic [`IRQ_W-1:0] ev;

    line_sum_if ls_if [3] ();

    for (genvar g = 0; g < 3; g++) begin : g_lane
        assign ls_if[g].clear   = lane_clear;
        assign ls_if[g].pix_vld = pix_vld_i;
        assign ls_if[g].pix     = pix_dec_i[g*8 +: 8];
        assign sums[g*8 +: 8]   = ls_if[g].sum;
        line_sum_lane u_lane (
            .clk_i   (clk_i),
            .rst_n_i (rst_n_i),
            .ls      (ls_if[g])
        );
    end

    // Mirror bits come from the link side
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mir_s1_r <= 8'h00;
            mir_s2_r <= 8'h00;
        end else begin
            mir_s1_r <= tx_debug_i & `MIRROR_MASK;
            mir_s2_r <= mir_s1_r;
        end
    end

    assign addr_idx   = haddr_i[9:2];
    assign addr_ph    = hsel_i && hready_i && htrans_i[1];
    assign lane_clear = st_r.chk_pend && chk_vld_i;
    assign sum_ok     = (sums == chk_i);
    assign p_per      = mir_s2_r[`BIT_FAST_VERIFY] ? `FRAMES_FAST_P : `FRAMES_SLOW_P;
    assign r_per      = mir_s2_r[`BIT_FAST_VERIFY] ? `FRAMES_FAST_R : `FRAMES_SLOW_R;
    assign tmr_lim    = mir_s2_r[`BIT_SPEEDUP] ? (8'hff >> `SPEEDUP_SHIFT) : 8'hff;

    always_comb begin
        st_nxt          = st_r;
        st_nxt.fc_due   = 1'b0;
        st_nxt.li_due   = 1'b0;
        st_nxt.tmr_tick = 1'b0;
        st_nxt.ds_en    = 1'b0;
        ev              = '0;

        // Bus idle timeout
        if (bus_activity_i || mir_s2_r[`BIT_TO_DIS]) begin
            st_nxt.idle_cnt = 32'h0;
            st_nxt.bus_free = 1'b0;
        end else if (st_r.idle_cnt >= BUS_IDLE_CYC) begin
            st_nxt.bus_free = 1'b1;
        end else begin
            st_nxt.idle_cnt = st_r.idle_cnt + 32'h1;
        end

        // Frame cadence
        if (frame_start_i) begin
            st_nxt.frame_cnt = (st_r.frame_cnt + 8'h1 >= r_per) ? 8'h00
                             : st_r.frame_cnt + 8'h1;
            // Wrap also forces a frame check so a mode change keeps both on one grid
            st_nxt.fc_due    = (((st_r.frame_cnt + 8'h1) & (p_per - 8'h1)) == 8'h00)
                             || (st_r.frame_cnt + 8'h1 >= r_per);
            st_nxt.li_due    = (st_r.frame_cnt + 8'h1 >= r_per);
        end

        // Authentication timer tick
        if (st_r.tmr_div >= tmr_lim) begin
            st_nxt.tmr_div  = 8'h00;
            st_nxt.tmr_tick = 1'b1;
        end else begin
            st_nxt.tmr_div = st_r.tmr_div + 8'h1;
        end

        // Authentication state
        case (st_r.au)
            AU_IDLE: begin
                if (auth_start_i) begin
                    st_nxt.au = AU_RUN;
                end
            end
            AU_RUN: begin
                if (auth_lost_i) begin
                    st_nxt.au = AU_IDLE;
                end else if (auth_ok_i) begin
                    st_nxt.au = AU_DONE;
                end
            end
            AU_DONE: begin
                if (auth_lost_i) begin
                    st_nxt.au = AU_IDLE;
                end else if (auth_start_i) begin
                    st_nxt.au = AU_RUN;
                end
            end
            default: st_nxt.au = AU_IDLE;
        endcase
        if (auth_start_i) begin
            st_nxt.ds_en = !(st_r.local_reg[`BIT_REENABLE] && ds_enabled_i);
        end
        if (auth_lost_i || auth_start_i) begin
            st_nxt.auth_done = 1'b0;
            ev[2]         = auth_lost_i;
        end else if (auth_ok_i && st_r.au == AU_RUN) begin
            st_nxt.auth_done = 1'b1;
            ev[0]         = 1'b1;
        end

        // Line checksum
        if (line_end_i && mir_s2_r[`BIT_CHK_EN]) begin
            st_nxt.chk_pend = 1'b1;
        end
        if (lane_clear) begin
            st_nxt.chk_pend = 1'b0;
        end

        // Pixel output
        st_nxt.rgb = st_r.local_reg[`BIT_NO_DECRYPT] ? pix_enc_i : pix_dec_i;

        // AHB slave
        case (st_r.ahb)
            AHB_WR: begin
                if (st_r.idx == `IDX_DEBUG_LOCAL) begin
                    st_nxt.local_reg = hwdata_i[7:0] & `LOCAL_MASK;
                end
                if (st_r.idx == `IDX_STATUS) begin
                    st_nxt.chk_err = 1'b0;
                end
                if (st_r.idx == `IDX_IRQ_MASK) begin
                    st_nxt.irq_mask = hwdata_i[`IRQ_W-1:0];
                end
            end
            AHB_RD: begin
                if (st_r.idx == `IDX_IRQ_STATUS) begin
                    // Clear only bits returned; events after the address phase survive
                    st_nxt.irq_sts = st_r.irq_sts & ~st_r.rdata[`IRQ_W-1:0];
                end
            end
            AHB_IDLE: ;
            default: st_nxt.ahb = AHB_IDLE;
        endcase
        st_nxt.ahb = AHB_IDLE;
        if (addr_ph) begin
            st_nxt.ahb   = hwrite_i ? AHB_WR : AHB_RD;
            st_nxt.idx   = addr_idx;
            st_nxt.rdata = 32'h0;
            if (!hwrite_i) begin
                case (addr_idx)
                    `IDX_DEBUG_MIRROR: st_nxt.rdata = {24'h0, mir_s2_r};
                    `IDX_DEBUG_LOCAL:  st_nxt.rdata = {24'h0, st_r.local_reg};
                    `IDX_STATUS:       st_nxt.rdata = {30'h0, st_r.chk_err, st_r.auth_done};
                    `IDX_IRQ_MASK:     st_nxt.rdata = {29'h0, st_r.irq_mask};
                    `IDX_IRQ_STATUS:   st_nxt.rdata = {29'h0, st_r.irq_sts};
                    default:           st_nxt.rdata = 32'h0;
                endcase
            end
        end

        // Set wins over software clear
        if (lane_clear && !sum_ok && mir_s2_r[`BIT_CHK_EN]) begin
            st_nxt.chk_err = 1'b1;
            ev[1]          = 1'b1;
        end
        st_nxt.irq_sts = st_nxt.irq_sts | ev;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r       <= '0;
            st_r.ahb   <= AHB_IDLE;
            st_r.au    <= AU_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hrdata_o             = st_r.rdata;
    assign hreadyout_o          = 1'b1;
    assign hresp_o              = 1'b0;
    assign irq_o                = |(st_r.irq_sts & st_r.irq_mask);
    assign bus_free_o           = st_r.bus_free;
    assign bus_fast_timing_o    = mir_s2_r[`BIT_FAST_I2C];
    assign frame_check_due_o    = st_r.fc_due;
    assign link_integrity_due_o = st_r.li_due;
    assign timer_tick_o         = st_r.tmr_tick;
    assign ds_enable_o          = st_r.ds_en;
    assign rgb_o                = st_r.rgb;
endmodule : cp_dbg_bank
`default_nettype wire

// ---- testbench/cp_dbg_bank_sva.sv ----
// Port checker for the protection debug/status bank.
// Assumes it is bound onto cp_dbg_bank; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module cp_dbg_bank_sva (
    input wire logic        clk_i,                // clock
    input wire logic        rst_n_i,              // reset, active low
    input wire logic        hsel_i,               // select
    input wire logic [31:0] haddr_i,              // address
    input wire logic [1:0]  htrans_i,             // transfer type
    input wire logic        hwrite_i,             // write
    input wire logic        hready_i,             // bus ready
    input wire logic [31:0] hrdata_o,             // read data
    input wire logic        hreadyout_o,          // slave ready
    input wire logic        hresp_o,              // response
    input wire logic [7:0]  tx_debug_i,           // debug bits
    input wire logic        bus_activity_i,       // bus activity
    input wire logic        bus_free_o,           // bus free
    input wire logic        bus_fast_timing_o,    // fast timing
    input wire logic        frame_start_i,        // frame start
    input wire logic        frame_check_due_o,    // check due
    input wire logic        link_integrity_due_o, // integrity due
    input wire logic        timer_tick_o,         // timer tick
    input wire logic        auth_start_i,         // auth start
    input wire logic        ds_enable_o,          // downstream enable
    input wire logic [23:0] pix_dec_i,            // clear pixel
    input wire logic [23:0] pix_enc_i,            // cipher pixel
    input wire logic [23:0] rgb_o                 // colour out
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_ready_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus answer not ready or not okay");
    a_unmapped_zero: assert property (hsel_i && hready_i && htrans_i[1] && !hwrite_i
        && haddr_i[9:2] == 8'hc2 |=> hrdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_fast_timing: assert property ($stable(tx_debug_i) [*3] |-> bus_fast_timing_o == tx_debug_i[0])
        else $error("fast timing select wrong");
    a_rgb_source: assert property (rgb_o == $past(pix_dec_i) || rgb_o == $past(pix_enc_i))
        else $error("colour output from neither source");
    a_tick_gap: assert property (timer_tick_o |=> !timer_tick_o [*8])
        else $error("timer ticks too close");
    a_due_cause: assert property (frame_check_due_o |-> $past(frame_start_i))
        else $error("frame check due without frame");
    a_integ_nested: assert property (link_integrity_due_o |-> frame_check_due_o)
        else $error("integrity due off the check grid");
    a_free_drop: assert property (bus_activity_i |=> !bus_free_o)
        else $error("bus free despite activity");
    a_dsen_cause: assert property (ds_enable_o |-> $past(auth_start_i) || $past(auth_start_i, 2))
        else $error("downstream enable without start");
    a_dsen_single: assert property (ds_enable_o |=> !ds_enable_o)
        else $error("downstream enable longer than a pulse");
endmodule : cp_dbg_bank_sva
bind cp_dbg_bank cp_dbg_bank_sva chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .tx_debug_i(tx_debug_i),
    .bus_activity_i(bus_activity_i), .bus_free_o(bus_free_o), .frame_start_i(frame_start_i),
    .bus_fast_timing_o(bus_fast_timing_o), .frame_check_due_o(frame_check_due_o),
    .link_integrity_due_o(link_integrity_due_o), .timer_tick_o(timer_tick_o),
    .auth_start_i(auth_start_i), .ds_enable_o(ds_enable_o), .pix_dec_i(pix_dec_i),
    .pix_enc_i(pix_enc_i), .rgb_o(rgb_o));
`default_nettype wire

// ---- testbench/tx_partner.sv ----
// Upstream transmitter model: debug settings, frames, pixel lines and checksums.
// Assumes tasks are called just after a rising edge of clk_i.
`timescale 1ns/1ns
`default_nettype none
module tx_partner (
    input  wire logic        clk_i,   // clock
    output var  logic [7:0]  dbg_o,   // debug settings
    output var  logic        frame_o, // frame start
    output var  logic        vld_o,   // pixel valid
    output var  logic        end_o,   // line end
    output var  logic        cvld_o,  // checksum valid
    output var  logic [23:0] chk_o,   // checksums
    output var  logic [23:0] dec_o,   // clear pixel
    output var  logic [23:0] enc_o    // cipher pixel
);
    initial {dbg_o, frame_o, vld_o, end_o, cvld_o, chk_o, dec_o, enc_o} = '0;
    task set_dbg(input logic [7:0] v);
        dbg_o <= v;
        repeat (5) @(posedge clk_i);
    endtask : set_dbg
    task frames(input int n);
        repeat (n) begin
            frame_o <= 1'b1;
            @(posedge clk_i) frame_o <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
    endtask : frames
    task line(input int n, input logic [23:0] r, input logic bad);
        int          s [3];
        logic [23:0] p;
        s = '{0, 0, 0};
        p = r;
        for (int i = 0; i < n; i++) begin
            vld_o <= 1'b1;
            dec_o <= p;
            enc_o <= p ^ 24'h5a5a5a;
            for (int c = 0; c < 3; c++) begin
                s[c] += p[8*c +: 8];
                if (s[c] > 255) s[c] -= 255;
            end
            p = p * 3 + r;
            @(posedge clk_i);
        end
        // Released pixel lines show the inverse of their last value
        {vld_o, end_o, dec_o, enc_o} <= {2'b01, ~dec_o, ~enc_o};
        @(posedge clk_i) {end_o, cvld_o} <= 2'b01;
        chk_o <= ~{s[2][7:0], s[1][7:0], s[0][7:0]} ^ {23'h0, bad};
        @(posedge clk_i) {cvld_o, chk_o} <= {1'b0, ~chk_o};
        @(posedge clk_i);
    endtask : line
endmodule : tx_partner
`default_nettype wire

// ---- testbench/content_protect_debug_status_tb.sv ----
// Self-checking bench of the protection debug/status bank.
// Assumes the checker is bound and tx_partner drives the link side.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, s); end end
module content_protect_debug_status_tb;
    logic        clk_i = 0, rst_n_i = 0, hsel_i = 0, hwrite_i = 0;
    logic        act = 0, ast = 0, aok = 0, alost = 0, dsen_i = 0;
    logic [1:0]  htrans_i = 0;
    logic [2:0]  hsize_i = 0;
    logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata, rd, r, seed = 32'h23;
    logic        hro, hresp, irq, bfree, bfast, fcd, lid, tick, dsen, fs, vld, le, cv;
    logic [7:0]  dbg, v;
    logic [23:0] chk, dec, enc, rgb;
    logic [31:0] amap [6] = '{32'h300, 32'h304, 32'h310, 32'h314, 32'h318, 32'h308};
    int          n_errors = 0, n_tests = 0, n_fcd = 0, n_lid = 0, n_ds = 0, g, f0, l0, d0;
    int          lcl = 0, cerr = 0, adone = 0, irqs = 0, mask = 0;
    cp_dbg_bank #(.BUS_IDLE_CYC(20)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
        .hready_i(hro), .hrdata_o(hrdata), .hreadyout_o(hro), .hresp_o(hresp), .irq_o(irq),
        .tx_debug_i(dbg), .bus_activity_i(act), .bus_free_o(bfree), .bus_fast_timing_o(bfast),
        .frame_start_i(fs), .frame_check_due_o(fcd), .link_integrity_due_o(lid),
        .timer_tick_o(tick), .auth_start_i(ast), .auth_ok_i(aok), .auth_lost_i(alost),
        .ds_enabled_i(dsen_i), .ds_enable_o(dsen), .pix_vld_i(vld), .line_end_i(le),
        .chk_vld_i(cv), .chk_i(chk), .pix_dec_i(dec), .pix_enc_i(enc), .rgb_o(rgb));
    tx_partner tx (.clk_i(clk_i), .dbg_o(dbg), .frame_o(fs), .vld_o(vld), .end_o(le),
        .cvld_o(cv), .chk_o(chk), .dec_o(dec), .enc_o(enc));
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        n_fcd += fcd;
        n_lid += lid;
        n_ds += dsen;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        {hsel_i, htrans_i, haddr_i, hwrite_i, hsize_i} <= {3'b110, a, w, 3'b010};
        @(posedge clk_i);
        while (hro !== 1'b1) @(posedge clk_i);
        {htrans_i, hwdata_i} <= {2'b00, d};
        @(posedge clk_i);
        while (hro !== 1'b1) @(posedge clk_i);
        rd = hrdata;
    endtask : ahb
    task rdchk(input string nm, input logic [31:0] a, input int e);
        ahb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask : rdchk
    task ev(input logic [2:0] e);
        {ast, aok, alost} <= e;
        @(posedge clk_i) {ast, aok, alost} <= 3'b000;
        repeat (3) @(posedge clk_i);
    endtask : ev
    task tickgap();
        do @(posedge clk_i); while (tick !== 1'b1);
        g = 0;
        do begin @(posedge clk_i); g++; end while (tick !== 1'b1);
    endtask : tickgap
    task end_sim();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    initial begin
        #200000;
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        foreach (amap[i]) rdchk("reset value", amap[i], 0);
        for (int k = 0; k < 2; k++) begin
            r = rnd();
            v = k ? ~r[7:0] : r[7:0];
            tx.set_dbg(v);
            rdchk("mirror", 32'h300, v & 8'h4f);
            ahb(1'b1, 32'h300, ~v);
            rdchk("mirror read only", 32'h300, v & 8'h4f);
            `CHK("fast timing", v[0], bfast)
        end
        for (int k = 0; k < 3; k++) begin
            tx.set_dbg(k < 2 ? 8'h08 : 8'h00);
            tx.line(5 + k, rnd(), k != 0);
            repeat (2) @(posedge clk_i);
            cerr = (k == 1);
            irqs |= cerr << 1;
            rdchk("checksum error", 32'h310, cerr << 1 | adone);
            ahb(1'b1, 32'h310, rnd());
            rdchk("checksum cleared", 32'h310, adone);
        end
        for (int k = 0; k < 2; k++) begin
            v = (rnd() & 8'hfd) | (k << 1);
            ahb(1'b1, 32'h304, v);
            lcl = v & 8'h03;
            rdchk("local", 32'h304, lcl);
            repeat (2) @(posedge clk_i);
            `CHK("colour out", lcl[1] ? enc : dec, rgb)
        end
        mask = 1;
        ahb(1'b1, 32'h314, mask);
        dsen_i <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            ahb(1'b1, 32'h304, k);
            d0 = n_ds;
            ev(3'b100);
            `CHK("downstream enable", k ? 0 : 1, n_ds - d0)
            adone = 0;
            rdchk("auth restart", 32'h310, adone);
            ev(3'b010);
            adone = 1;
            irqs |= 1;
            rdchk("authenticated", 32'h310, adone);
            `CHK("irq raised", 1'b1, irq)
            rdchk("irq status", 32'h318, irqs);
            irqs = 0;
            // The read clear lands at the data phase edge; look one cycle later
            @(posedge clk_i);
            `CHK("irq cleared", 1'b0, irq)
        end
        ev(3'b001);
        adone = 0;
        rdchk("auth lost", 32'h310, adone);
        rdchk("irq lost masked", 32'h318, 4);
        for (int k = 0; k < 2; k++) begin
            tx.set_dbg(k ? 8'h02 : 8'h00);
            tickgap();
            tickgap();
            `CHK("tick gap", k ? 16 : 256, g)
        end
        for (int k = 0; k < 2; k++) begin
            tx.set_dbg(k ? 8'h00 : 8'h04);
            f0 = n_fcd;
            l0 = n_lid;
            tx.frames(k ? 128 : 16);
            repeat (3) @(posedge clk_i);
            `CHK("frame checks", 8, n_fcd - f0)
            `CHK("integrity checks", 1, n_lid - l0)
        end
        for (int k = 0; k < 2; k++) begin
            tx.set_dbg(k ? 8'h40 : 8'h00);
            act <= 1'b1;
            @(posedge clk_i) act <= 1'b0;
            repeat (15) @(posedge clk_i);
            `CHK("bus free early", 1'b0, bfree)
            repeat (15) @(posedge clk_i);
            `CHK("bus free", k ? 1'b0 : 1'b1, bfree)
        end
        end_sim();
    end
endmodule : content_protect_debug_status_tb
`default_nettype wire
